// *** hdl/edc_consts.svh ***
`ifndef EDC_CONSTS_SVH
`define EDC_CONSTS_SVH

// register byte offsets
`define EDC_OFF_STATUS        5'h00
`define EDC_OFF_CMD           5'h04
`define EDC_OFF_PTBASE        5'h08
`define EDC_OFF_RXHEAD        5'h0c
`define EDC_OFF_TXHEAD        5'h10
`define EDC_OFF_EVENT         5'h14
`define EDC_ADDR_W            5

// status field positions
`define EDC_ST_RXSTATE_LO     22
`define EDC_ST_TXSTATE_LO     24
`define EDC_ST_STCODE_LO      26
`define EDC_ST_STFAIL         30
`define EDC_ST_INIT           31
`define EDC_ST_BOOT           7

// command field positions
`define EDC_CM_AF_LO          1
`define EDC_CM_PB             3
`define EDC_CM_FC             6
`define EDC_CM_DC             7
`define EDC_CM_OM_LO          8
`define EDC_CM_SR             10
`define EDC_CM_ST             11
`define EDC_CM_SE             19
`define EDC_CM_BE             20
`define EDC_CM_BL_LO          25
`define EDC_CM_IE             30
`define EDC_CM_RE             31

`define EDC_CMD_WR_MASK       32'h5e180fce
`define EDC_CMD_RESET         32'h02000000
`define EDC_PTBASE_MASK       32'h3fffffff

// timing
`define EDC_SELFTEST_MS       25
`define EDC_CLK_HZ            10000000
`define EDC_SELFTEST_CYC      ((`EDC_SELFTEST_MS * `EDC_CLK_HZ) / 1000)
`define EDC_BOOT_T            4
`define EDC_BOOT_CYC          (6 * `EDC_BOOT_T)

`endif

// *** hdl/edc_pkg.sv ***
package edc_pkg;

	typedef enum logic [1:0] {
		EDC_PROC_STOPPED   = 2'h0,
		EDC_PROC_RUNNING   = 2'h1,
		EDC_PROC_SUSPENDED = 2'h2
	} edc_proc_t;

	typedef enum logic [1:0] {
		EDC_INIT_RESET = 2'h0,
		EDC_INIT_TEST  = 2'h1,
		EDC_INIT_READY = 2'h3
	} edc_init_t;

	typedef enum logic [3:0] {
		EDC_ST_OK       = 4'h0,
		EDC_ST_ROM      = 4'h1,
		EDC_ST_RAM      = 4'h2,
		EDC_ST_FILT_RAM = 4'h3,
		EDC_ST_TX_FIFO  = 4'h4,
		EDC_ST_RX_FIFO  = 4'h5,
		EDC_ST_LOOPBACK = 4'h6
	} edc_stcode_t;

	// events from the datapath: frame boundaries, descriptor availability
	typedef struct packed {
		logic rx_frame_busy;
		logic tx_frame_busy;
		logic rx_desc_avail;
		logic tx_desc_avail;
		logic boot_msg_seen;
		logic [5:0] event_bits;
	} edc_dp_status_t;

	// mode outputs to the datapath
	typedef struct packed {
		logic [1:0] address_filter_mode;
		logic       pass_damaged_frames;
		logic       force_collision;
		logic       disable_rx_chaining;
		logic [1:0] loopback_select;
		logic       single_burst_enable;
		logic [3:0] burst_limit;
	} edc_mode_t;

endpackage

// *** hdl/edc_cmd_status.sv ***
`timescale 1ns/100ps
`include "edc_consts.svh"
// How it works
// - rx state field: 00 stop, 01 run, 10 suspend
// - tx state field: same encoding
// - four-bit self-test code, 25 ms test
// - self-test failed flag with code
// - init flag clear during init, commands other than reset ignored
// - both processes stopped after init
// - two-bit address filter mode
// - pass damaged frames bit
// - force collision valid in internal loopback
// - disable rx chaining bit
// - two-bit loopback mode select
// - rx start runs, suspends without descriptor
// - rx start from stopped, needs list head
// - rx stop after current frame, position kept
// - tx start from stopped, needs list head
// - tx stop after current frame, position kept
// - single burst mode
// - burst limit 1/2/4/8, forced, init 1
// - boot message sets flag, pulses pin
// - interrupt on event bits when enabled
// - reset command reruns init, zero ignored
// - list heads writable only when not running
module edc_cmd_status #(
	parameter int SELFTEST_CYC = `EDC_SELFTEST_CYC,
	parameter int BOOT_CYC     = `EDC_BOOT_CYC
) (
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	input  wire logic [`EDC_ADDR_W-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	input  wire edc_pkg::edc_dp_status_t dp_status,
	input  wire logic [3:0]             selftest_result,
	output edc_pkg::edc_mode_t          mode,
	output logic [29:0]                 rx_list_head,
	output logic [29:0]                 tx_list_head,
	output logic [29:0]                 page_table_base,
	output logic                        rx_fetch_req,
	output logic                        tx_fetch_req,
	output logic                        boot_out_n,
	output logic                        irq
);
	edc_pkg::edc_init_t   init_reg;
	edc_pkg::edc_proc_t   rx_state_reg;
	edc_pkg::edc_proc_t   tx_state_reg;
	edc_pkg::edc_stcode_t stcode_reg;
	logic [31:0] cmd_reg;
	logic [29:0] rx_head_reg;
	logic [29:0] tx_head_reg;
	logic [29:0] ptbase_reg;
	logic        rx_head_written_reg;
	logic        tx_head_written_reg;
	logic        stfail_reg;
	logic [5:0]  event_reg;
	logic        boot_flag_reg;
	logic [31:0] init_cnt_reg;
	logic [15:0] boot_cnt_reg;
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic        irq_reg;
	logic [3:0]  sel_reg;
	edc_pkg::edc_dp_status_t dp_reg;
	edc_pkg::edc_mode_t      mode_reg;
	logic        rx_fetch_reg;
	logic        tx_fetch_reg;

	function automatic logic [31:0] byte_mask(input logic [3:0] be);
		byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	wire logic req = (avs_read | avs_write) & ~ack_reg;
	wire logic wr  = avs_write & ack_reg;
	wire logic ready = (init_reg == edc_pkg::EDC_INIT_READY);
	wire logic [31:0] wdata = avs_writedata & byte_mask(avs_byteenable);
	wire logic re_cmd = wr && avs_address == 5'(`EDC_OFF_CMD) && wdata[`EDC_CM_RE];
	wire logic cmd_wr = wr && avs_address == 5'(`EDC_OFF_CMD) && ready && !wdata[`EDC_CM_RE];
	wire logic sr_bit = cmd_reg[`EDC_CM_SR];
	wire logic st_bit = cmd_reg[`EDC_CM_ST];
	wire logic test_done = (init_cnt_reg >= 32'(SELFTEST_CYC - 1));
	wire logic rx_head_wr = wr && ready && avs_address == 5'(`EDC_OFF_RXHEAD);
	wire logic tx_head_wr = wr && ready && avs_address == 5'(`EDC_OFF_TXHEAD);
	wire logic evt_clr = wr && avs_address == 5'(`EDC_OFF_EVENT);
	wire logic boot_hit = cmd_reg[`EDC_CM_BE] && dp_reg.boot_msg_seen;

	function automatic logic [3:0] burst_fix(input logic [3:0] bl, input logic se);
		logic [3:0] v;
		v = bl;
		if (se && v == 4'h2) begin
			v = 4'h1;
		end else if (se && v == 4'h8) begin
			v = 4'h4;
		end
		burst_fix = v;
	endfunction

	// next state of a process; start honored only from stopped, stop waits for frame end
	function automatic edc_pkg::edc_proc_t proc_next(input edc_pkg::edc_proc_t s, input logic run,
			input logic head_ok, input logic avail, input logic busy);
		edc_pkg::edc_proc_t n;
		n = s;
		case (s)
			edc_pkg::EDC_PROC_STOPPED: begin
				if (run && head_ok) begin
					n = avail ? edc_pkg::EDC_PROC_RUNNING : edc_pkg::EDC_PROC_SUSPENDED;
				end
			end
			edc_pkg::EDC_PROC_RUNNING: begin
				if (!run && !busy) begin
					n = edc_pkg::EDC_PROC_STOPPED;
				end else if (run && !avail && !busy) begin
					n = edc_pkg::EDC_PROC_SUSPENDED;
				end
			end
			edc_pkg::EDC_PROC_SUSPENDED: begin
				if (!run) begin
					n = edc_pkg::EDC_PROC_STOPPED;
				end else if (avail) begin
					n = edc_pkg::EDC_PROC_RUNNING;
				end
			end
			default: n = edc_pkg::EDC_PROC_STOPPED;
		endcase
		proc_next = n;
	endfunction

	// bus handshake: one wait cycle, then answer
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dp_reg <= '0;
			sel_reg <= 4'h0;
		end else begin
			dp_reg <= dp_status;
			sel_reg <= selftest_result;
		end
	end

	// init sequencer: reset step, then a fixed-length self-test
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			init_reg <= edc_pkg::EDC_INIT_RESET;
		end else if (re_cmd) begin
			init_reg <= edc_pkg::EDC_INIT_RESET;
		end else begin
			case (init_reg)
				edc_pkg::EDC_INIT_RESET: begin
					init_reg <= edc_pkg::EDC_INIT_TEST;
				end
				edc_pkg::EDC_INIT_TEST: begin
					if (test_done) begin
						init_reg <= edc_pkg::EDC_INIT_READY;
					end
				end
				edc_pkg::EDC_INIT_READY: begin
					init_reg <= edc_pkg::EDC_INIT_READY;
				end
				default: begin
					init_reg <= edc_pkg::EDC_INIT_RESET;
				end
			endcase
		end
	end

	// self-test length counter, restarts on every entry to the test
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			init_cnt_reg <= 32'h0;
		end else if (re_cmd || init_reg != edc_pkg::EDC_INIT_TEST) begin
			init_cnt_reg <= 32'h0;
		end else if (!test_done) begin
			init_cnt_reg <= init_cnt_reg + 32'h1;
		end
	end

	// result kept until the next test ends, so a rerun does not blank it early
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			stcode_reg <= edc_pkg::EDC_ST_OK;
			stfail_reg <= 1'b0;
		end else if (!re_cmd && init_reg == edc_pkg::EDC_INIT_TEST && test_done) begin
			stcode_reg <= edc_pkg::edc_stcode_t'(sel_reg);
			stfail_reg <= (sel_reg != 4'h0);
		end
	end

	// command/mode register; ignored until init done
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cmd_reg <= `EDC_CMD_RESET;
		end else if (re_cmd || init_reg != edc_pkg::EDC_INIT_READY) begin
			cmd_reg <= `EDC_CMD_RESET;
		end else if (cmd_wr) begin
			cmd_reg <= (cmd_reg & ~(byte_mask(avs_byteenable) & `EDC_CMD_WR_MASK))
				| (wdata & `EDC_CMD_WR_MASK);
		end
	end

	// list heads move only while their process is not running
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_head_reg <= 30'h0;
		end else if (rx_head_wr && rx_state_reg != edc_pkg::EDC_PROC_RUNNING) begin
			rx_head_reg <= wdata[29:0];
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_head_written_reg <= 1'b0;
		end else if (re_cmd) begin
			rx_head_written_reg <= 1'b0;
		end else if (rx_head_wr && rx_state_reg != edc_pkg::EDC_PROC_RUNNING) begin
			rx_head_written_reg <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_head_reg <= 30'h0;
		end else if (tx_head_wr && tx_state_reg != edc_pkg::EDC_PROC_RUNNING) begin
			tx_head_reg <= wdata[29:0];
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_head_written_reg <= 1'b0;
		end else if (re_cmd) begin
			tx_head_written_reg <= 1'b0;
		end else if (tx_head_wr && tx_state_reg != edc_pkg::EDC_PROC_RUNNING) begin
			tx_head_written_reg <= 1'b1;
		end
	end

	// later rewrites still land; keeping them out is software's job
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ptbase_reg <= 30'h0;
		end else if (wr && ready && avs_address == 5'(`EDC_OFF_PTBASE)) begin
			ptbase_reg <= wdata[29:0];
		end
	end

	// process states, held stopped while initializing
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_state_reg <= edc_pkg::EDC_PROC_STOPPED;
		end else if (!ready || re_cmd) begin
			rx_state_reg <= edc_pkg::EDC_PROC_STOPPED;
		end else begin
			rx_state_reg <= proc_next(rx_state_reg, sr_bit, rx_head_written_reg,
				dp_reg.rx_desc_avail, dp_reg.rx_frame_busy);
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_state_reg <= edc_pkg::EDC_PROC_STOPPED;
		end else if (!ready || re_cmd) begin
			tx_state_reg <= edc_pkg::EDC_PROC_STOPPED;
		end else begin
			tx_state_reg <= proc_next(tx_state_reg, st_bit, tx_head_written_reg,
				dp_reg.tx_desc_avail, dp_reg.tx_frame_busy);
		end
	end

	// one-cycle fetch pulse on an honored start
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_fetch_reg <= 1'b0;
		end else if (!ready || re_cmd) begin
			rx_fetch_reg <= 1'b0;
		end else begin
			rx_fetch_reg <= (rx_state_reg == edc_pkg::EDC_PROC_STOPPED) && sr_bit && rx_head_written_reg;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_fetch_reg <= 1'b0;
		end else if (!ready || re_cmd) begin
			tx_fetch_reg <= 1'b0;
		end else begin
			tx_fetch_reg <= (tx_state_reg == edc_pkg::EDC_PROC_STOPPED) && st_bit && tx_head_written_reg;
		end
	end

	// sticky events, write one to clear, set wins
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			event_reg <= 6'h0;
		end else if (evt_clr) begin
			event_reg <= (event_reg & ~wdata[6:1]) | dp_reg.event_bits;
		end else begin
			event_reg <= event_reg | dp_reg.event_bits;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			boot_flag_reg <= 1'b0;
		end else if (boot_hit) begin
			boot_flag_reg <= 1'b1;
		end else if (evt_clr && wdata[`EDC_ST_BOOT]) begin
			boot_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			boot_cnt_reg <= 16'h0;
			boot_out_n <= 1'b1;
		end else begin
			if (boot_hit) begin
				boot_cnt_reg <= 16'(BOOT_CYC);
			end else if (boot_cnt_reg != 16'h0) begin
				boot_cnt_reg <= boot_cnt_reg - 16'h1;
			end
			boot_out_n <= !(boot_hit || boot_cnt_reg > 16'h1);
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= cmd_reg[`EDC_CM_IE] && (event_reg != 6'h0);
		end
	end

	// read mux
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rdata_reg <= 32'h0;
		end else if (req && avs_read) begin
			case (avs_address)
				5'(`EDC_OFF_STATUS): rdata_reg <= {ready, stfail_reg, stcode_reg, tx_state_reg, rx_state_reg,
					14'h0, boot_flag_reg, event_reg, |event_reg};
				5'(`EDC_OFF_CMD):    rdata_reg <= cmd_reg;
				5'(`EDC_OFF_PTBASE): rdata_reg <= {2'h0, ptbase_reg};
				5'(`EDC_OFF_RXHEAD): rdata_reg <= {2'h0, rx_head_reg};
				5'(`EDC_OFF_TXHEAD): rdata_reg <= {2'h0, tx_head_reg};
				default:             rdata_reg <= 32'h0;
			endcase
		end
	end

	// mode outputs
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mode_reg <= '0;
		end else begin
			mode_reg.address_filter_mode <= cmd_reg[`EDC_CM_AF_LO+1:`EDC_CM_AF_LO];
			mode_reg.pass_damaged_frames <= cmd_reg[`EDC_CM_PB];
			mode_reg.force_collision <= cmd_reg[`EDC_CM_FC] && cmd_reg[`EDC_CM_OM_LO+1:`EDC_CM_OM_LO] == 2'h1;
			mode_reg.disable_rx_chaining <= cmd_reg[`EDC_CM_DC];
			mode_reg.loopback_select <= cmd_reg[`EDC_CM_OM_LO+1:`EDC_CM_OM_LO];
			mode_reg.single_burst_enable <= cmd_reg[`EDC_CM_SE];
			mode_reg.burst_limit <= burst_fix(cmd_reg[`EDC_CM_BL_LO+3:`EDC_CM_BL_LO], cmd_reg[`EDC_CM_SE]);
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = ~ack_reg;
	assign mode            = mode_reg;
	assign rx_list_head    = rx_head_reg;
	assign tx_list_head    = tx_head_reg;
	assign page_table_base = ptbase_reg;
	assign rx_fetch_req    = rx_fetch_reg;
	assign tx_fetch_req    = tx_fetch_reg;
	assign irq             = irq_reg;
endmodule

// *** tb/edc_cmd_status_asserts.sv ***
`timescale 1ns/100ps
module edc_cmd_status_asserts #(
	parameter int SELFTEST_CYC = 10,
	parameter int BOOT_CYC = 24
) (
	input wire logic	core_clk,
	input wire logic	reset,
	input wire logic [4:0]	avs_address,
	input wire logic	avs_read,
	input wire logic	avs_write,
	input wire logic [31:0]	avs_writedata,
	input wire logic [3:0]	avs_byteenable,
	input wire logic [31:0]	avs_readdata,
	input wire logic	avs_waitrequest,
	input wire edc_pkg::edc_dp_status_t	dp_status,
	input wire logic [3:0]	selftest_result,
	input wire edc_pkg::edc_mode_t	mode,
	input wire logic [29:0]	rx_list_head,
	input wire logic [29:0]	tx_list_head,
	input wire logic [29:0]	page_table_base,
	input wire logic	rx_fetch_req,
	input wire logic	tx_fetch_req,
	input wire logic	boot_out_n,
	input wire logic	irq
);
	int	low_cnt;
	logic	c_w, rx_w, tx_w;
	// a command write is also allowed, though a reset command never reloads the heads
	assign c_w = avs_write && !avs_waitrequest && avs_address == 5'h04;
	assign rx_w = c_w || (avs_write && !avs_waitrequest && avs_address == 5'h0c);
	assign tx_w = c_w || (avs_write && !avs_waitrequest && avs_address == 5'h10);
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			low_cnt <= 0;
		end else if (boot_out_n) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= low_cnt + 1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_answer: assert property (p_answer) else $error("bus request not answered");
	property p_fc; mode.force_collision |-> mode.loopback_select == 2'h1; endproperty
	a_fc: assert property (p_fc) else $error("collision forced outside internal loopback");
	property p_burst; mode.single_burst_enable |-> mode.burst_limit inside {4'h1, 4'h4}; endproperty
	a_burst: assert property (p_burst) else $error("burst limit not folded");
	property p_boot; $rose(boot_out_n) |-> low_cnt >= BOOT_CYC - 2 && low_cnt <= BOOT_CYC + 2; endproperty
	a_boot: assert property (p_boot) else $error("boot pin pulse length wrong");
	property p_rxf; rx_fetch_req |=> !rx_fetch_req; endproperty
	a_rxf: assert property (p_rxf) else $error("rx fetch request not a pulse");
	property p_txf; tx_fetch_req |=> !tx_fetch_req; endproperty
	a_txf: assert property (p_txf) else $error("tx fetch request not a pulse");
	property p_rxh; $changed(rx_list_head) |-> $past(rx_w) || $past(rx_w, 2); endproperty
	a_rxh: assert property (p_rxh) else $error("rx head changed without a write");
	property p_txh; $changed(tx_list_head) |-> $past(tx_w) || $past(tx_w, 2); endproperty
	a_txh: assert property (p_txh) else $error("tx head changed without a write");
	c_fetch: cover property (rx_fetch_req);
	c_boot: cover property ($fell(boot_out_n));
	c_irq: cover property ($rose(irq));
endmodule
bind edc_cmd_status edc_cmd_status_asserts #(.SELFTEST_CYC(SELFTEST_CYC), .BOOT_CYC(BOOT_CYC)) u_chk (.*);

// *** tb/edc_dp_model.sv ***
`timescale 1ns/100ps
module edc_dp_model #(
	parameter int BUSY = 6
) (
	input wire logic	core_clk,
	input wire logic	reset,
	input wire logic	rx_fetch_req,
	input wire logic	tx_fetch_req,
	input wire logic [1:0]	avail,
	input wire logic [5:0]	ev,
	input wire logic	boot,
	input wire logic [3:0]	code,
	output edc_pkg::edc_dp_status_t	dp_status,
	output logic [3:0]	selftest_result
);
	int	rx_cnt, tx_cnt;
	// a fetched descriptor keeps a frame in flight, so stops and suspends land late
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_cnt <= 0;
			tx_cnt <= 0;
		end else begin
			rx_cnt <= (rx_fetch_req && avail[0]) ? BUSY : ((rx_cnt > 0) ? rx_cnt - 1 : 0);
			tx_cnt <= (tx_fetch_req && avail[1]) ? BUSY : ((tx_cnt > 0) ? tx_cnt - 1 : 0);
		end
	end
	assign dp_status = '{rx_cnt > 0, tx_cnt > 0, avail[0], avail[1], boot, ev};
	assign selftest_result = code;
endmodule

// *** tb/tb_edc_cmd_status.sv ***
`timescale 1ns/100ps
module tb_edc_cmd_status;
	localparam int ST = 10;
	localparam int BC = 24;
	logic	core_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, boot = 1'b0;
	logic [4:0]	avs_address = 5'h0;
	logic [31:0]	avs_writedata = 32'h0, avs_readdata, m;
	logic [3:0]	avs_byteenable = 4'hf, selftest_result, code = 4'h0;
	logic	avs_waitrequest, rx_fetch_req, tx_fetch_req, boot_out_n, irq;
	edc_pkg::edc_dp_status_t	dp_status;
	edc_pkg::edc_mode_t	mode, em;
	logic [29:0]	rx_list_head, tx_list_head, page_table_base, h;
	logic [1:0]	avail = 2'h3;
	logic [5:0]	ev = 6'h0;
	logic [31:0]	eq[$], mq[$];
	int	miscompares = 0, num_checks = 0;
	edc_cmd_status #(.SELFTEST_CYC(ST), .BOOT_CYC(BC)) DUT (.*);
	edc_dp_model u_dp (.*);
	always #50 core_clk = ~core_clk;
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// request held until the edge that samples waitrequest low, then one idle edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] msk);
		eq.push_back(e);
		mq.push_back(msk);
		bus(1'b0, a, 32'h0);
	endtask
	always @(posedge core_clk) begin
		if (avs_read && avs_waitrequest === 1'b0 && eq.size() > 0) begin
			m = mq.pop_front();
			chk("readdata", avs_readdata & m, eq.pop_front() & m);
		end
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(3000);
		miscompares++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h9032));
		cyc(5);
		reset <= 1'b0;
		cyc(1);
		rd(5'h00, 32'h0, 32'h80000000);
		bus(1'b1, 5'h04, 32'h02000c00);
		cyc(ST + 4);
		rd(5'h00, 32'h80000000, 32'hffc00000);
		rd(5'h04, 32'h02000000, 32'h5e180fce);
		rd(5'h1c, 32'h0, 32'hffffffff);
		avs_byteenable <= 4'h3;
		bus(1'b1, 5'h08, 32'hffffffff);
		avs_byteenable <= 4'hf;
		rd(5'h08, 32'h0000ffff, 32'hffffffff);
		bus(1'b1, 5'h04, 32'h02000400);
		cyc(4);
		rd(5'h00, 32'h0, 32'h03c00000);
		bus(1'b1, 5'h04, 32'h02000000);
		h = 30'($urandom);
		bus(1'b1, 5'h0c, {2'h0, h});
		bus(1'b1, 5'h10, {2'h0, ~h});
		chk("rx_head", {2'h0, rx_list_head}, {2'h0, h});
		chk("tx_head", {2'h0, tx_list_head}, {2'h0, ~h});
		chk("page_base", {2'h0, page_table_base}, 32'h0000ffff);
		bus(1'b1, 5'h04, 32'h02000c00);
		cyc(4);
		rd(5'h00, 32'h01400000, 32'h03c00000);
		bus(1'b1, 5'h0c, 32'h0);
		chk("rx_head", {2'h0, rx_list_head}, {2'h0, h});
		avail <= 2'h0;
		cyc(12);
		rd(5'h00, 32'h02800000, 32'h03c00000);
		bus(1'b1, 5'h0c, 32'h0);
		chk("rx_head", {2'h0, rx_list_head}, 32'h0);
		avail <= 2'h3;
		bus(1'b1, 5'h04, 32'h02000000);
		cyc(12);
		rd(5'h00, 32'h0, 32'h03c00000);
		// stop issued while a frame is in flight: stays running until it ends
		bus(1'b1, 5'h04, 32'h02000c00);
		bus(1'b1, 5'h04, 32'h02000000);
		rd(5'h00, 32'h01400000, 32'h03c00000);
		cyc(12);
		rd(5'h00, 32'h0, 32'h03c00000);
		for (int i = 0; i < 8; i++) begin
			em = edc_pkg::edc_mode_t'($urandom);
			em.address_filter_mode = i[2:1];
			em.loopback_select = i[1:0];
			em.burst_limit = 4'h1 << i[1:0];
			em.single_burst_enable = i[0] ^ i[2];
			bus(1'b1, 5'h04, {3'h0, em.burst_limit, 5'h0, em.single_burst_enable, 9'h0, em.loopback_select,
				em.disable_rx_chaining, em.force_collision, 2'h0, em.pass_damaged_frames, em.address_filter_mode, 1'b0});
			if (em.loopback_select != 2'h1) em.force_collision = 1'b0;
			if (em.single_burst_enable && em.burst_limit inside {4'h2, 4'h8}) em.burst_limit = em.burst_limit >> 1;
			cyc(2);
			chk("mode", 32'(mode), 32'(em));
		end
		ev <= 6'h04;
		cyc(1);
		ev <= 6'h0;
		cyc(4);
		chk("irq", {31'h0, irq}, 32'h0);
		bus(1'b1, 5'h04, 32'h42000000);
		cyc(3);
		chk("irq", {31'h0, irq}, 32'h1);
		bus(1'b1, 5'h14, 32'h000000fe);
		cyc(3);
		chk("irq", {31'h0, irq}, 32'h0);
		bus(1'b1, 5'h04, 32'h02100000);
		boot <= 1'b1;
		cyc(1);
		boot <= 1'b0;
		cyc(4);
		chk("boot_out_n", {31'h0, boot_out_n}, 32'h0);
		rd(5'h00, 32'h80, 32'h80);
		cyc(BC);
		chk("boot_out_n", {31'h0, boot_out_n}, 32'h1);
		for (int c = 1; c < 7; c++) begin
			code <= 4'(c);
			bus(1'b1, 5'h04, 32'h82000000);
			rd(5'h00, 32'h0, 32'h80000000);
			cyc(ST + 4);
			rd(5'h00, {2'h3, 4'(c), 26'h0}, 32'hffc00000);
		end
		end_of_test();
	end
endmodule
